//--- core/ssra_slave.v
// Purpose: Serial-bus slave giving access to the register map by pointer.
// Assumes: SCL and SDA are asynchronous pins, sampled by clk.
// Notes:   Register file beyond config one lives outside; it is reached
//          by the reg_* strobes and the reg_rdata return.
`timescale 1ns/1ps
`include "ssra_defines.vh"

module ssra_slave
#(
	parameter TIMEOUT_CYCLES = `SSRA_TIMEOUT_CYCLES
)
(
	// Clock, reset, enable
	input  wire       clk,
	input  wire       rst,
	input  wire       ce,
	// Bus pins
	input  wire       scl_in,
	input  wire       sda_in,
	output wire       sda_out,
	output wire       sda_oe,
	// Address select pin levels (high, low, float decoded outside)
	input  wire       addr_sel_high,
	input  wire       addr_sel_low,
	// Alert
	input  wire       alert_cause,
	output wire       alert_n_out,
	output wire       alert_n_oe,
	// Register file access
	output reg  [7:0] reg_addr,
	output reg  [7:0] reg_wdata,
	output reg        reg_we,
	input  wire [7:0] reg_rdata,
	// Configuration and state
	output reg  [7:0] config_one,
	output reg        timeout_disable,
	output reg  [6:0] own_addr,
	output reg        timeout_hit
);

	// ------------------------------------------------------------------
	// States
	// ------------------------------------------------------------------
	localparam ST_IDLE = 3'd0;  // Waiting for start
	localparam ST_RECV = 3'd1;  // Shifting in a byte
	localparam ST_ACK  = 3'd2;  // Driving acknowledge
	localparam ST_SEND = 3'd3;  // Shifting out a byte
	localparam ST_RACK = 3'd4;  // Sampling master acknowledge
	localparam ST_SKIP = 3'd5;  // Not addressed, wait for stop/start

	// Byte phases within a transfer
	localparam PH_ADDR = 2'd0;
	localparam PH_CMD  = 2'd1;
	localparam PH_DATA = 2'd2;
	localparam PH_PEC  = 2'd3;

	// ------------------------------------------------------------------
	// Input synchronisers
	// ------------------------------------------------------------------
	reg [1:0] scl_sync;         // Two-stage SCL
	reg [1:0] sda_sync;         // Two-stage SDA
	reg [1:0] sel_hi_sync;      // Two-stage select high
	reg [1:0] sel_lo_sync;      // Two-stage select low
	reg [1:0] alert_sync;       // Two-stage alert cause
	reg       scl_d;            // Previous synchronised SCL
	reg       sda_d;            // Previous synchronised SDA

	// Sample all pins twice before use
	always @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			scl_sync    <= 2'b11;
			sda_sync    <= 2'b11;
			sel_hi_sync <= 2'b00;
			sel_lo_sync <= 2'b00;
			alert_sync  <= 2'b00;
			scl_d       <= 1'b1;
			sda_d       <= 1'b1;
		end
		else if (ce)
		begin
			scl_sync    <= {scl_sync[0], scl_in};
			sda_sync    <= {sda_sync[0], sda_in};
			sel_hi_sync <= {sel_hi_sync[0], addr_sel_high};
			sel_lo_sync <= {sel_lo_sync[0], addr_sel_low};
			alert_sync  <= {alert_sync[0], alert_cause};
			scl_d       <= scl_sync[1];
			sda_d       <= sda_sync[1];
		end
	end

	// Bus events from the synchronised levels
	wire scl    = scl_sync[1];
	wire sda    = sda_sync[1];
	wire scl_up = scl & ~scl_d;
	wire scl_dn = ~scl & scl_d;
	wire start  = scl & scl_d & sda_d & ~sda;
	wire stop   = scl & scl_d & ~sda_d & sda;

	// ------------------------------------------------------------------
	// Transfer state
	// ------------------------------------------------------------------
	reg [2:0] state;            // Current state
	reg [1:0] phase;            // Which byte of the transfer
	reg [2:0] bit_cnt;          // Bit index, counts down
	reg       byte_full;        // Eight bits shifted in
	reg [7:0] shreg;            // Shift register
	reg       rd_dir;           // Current transfer is a read
	reg       ara_mode;         // Answering alert response address
	reg       drive_low;        // Pull SDA low
	reg       addr_latched;     // Select pin already captured
	reg       alert_held;       // Alert output asserted
	reg [7:0] rdata_hold;       // Byte being sent
	reg [31:0] idle_cnt;        // Timeout counter

	// CRC over the data bits seen or sent since start; acknowledge bits are not shifted in
	wire [7:0] crc;
	wire       crc_shift;
	wire       crc_bit;
	assign crc_shift = scl_up && (state == ST_RECV || state == ST_SEND);
	assign crc_bit   = sda;

	ssra_crc8 u_crc
	(
		.clk    (clk),
		.rst    (rst),
		.ce     (ce),
		.clear  (start),
		.shift  (crc_shift),
		.bit_in (crc_bit),
		.crc    (crc)
	);

	// Open-drain drive of SDA and the alert line
	assign sda_out     = 1'b0;
	assign sda_oe      = drive_low;
	assign alert_n_out = 1'b0;
	assign alert_n_oe  = alert_held;

	// Decode of the received address byte
	wire hit_own = (shreg[7:1] == own_addr);
	wire hit_ara = (shreg[7:1] == `SSRA_ALERT_RESP_ADDR) & shreg[0]
		& alert_held;

	// Pin decode for the device address
	reg [6:0] next_own_addr;
	always @*
	begin
		if (sel_hi_sync[1])
			next_own_addr = `SSRA_ADDR_PIN_HIGH;
		else if (sel_lo_sync[1])
			next_own_addr = `SSRA_ADDR_PIN_LOW;
		else
			next_own_addr = `SSRA_ADDR_PIN_FLOAT;
	end

	// ------------------------------------------------------------------
	// Alert output
	// ------------------------------------------------------------------
	// Follows the cause; cleared only when cause is gone
	always @(posedge clk or posedge rst)
	begin
		if (rst)
			alert_held <= 1'b0;
		else if (ce)
			alert_held <= alert_sync[1];
	end

	// ------------------------------------------------------------------
	// Timeout counter
	// ------------------------------------------------------------------
	// Counts while a transfer is open and the bus is still
	always @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			idle_cnt    <= 32'h00000000;
			timeout_hit <= 1'b0;
		end
		else if (ce)
		begin
			timeout_hit <= 1'b0;
			if (state == ST_IDLE || timeout_disable
				|| scl_up || scl_dn || start || stop)
				idle_cnt <= 32'h00000000;
			else if (idle_cnt >= TIMEOUT_CYCLES)
			begin
				idle_cnt    <= 32'h00000000;
				timeout_hit <= 1'b1;
			end
			else
				idle_cnt <= idle_cnt + 32'h00000001;
		end
	end

	// ------------------------------------------------------------------
	// Main protocol machine
	// ------------------------------------------------------------------
	always @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			state           <= ST_IDLE;
			phase           <= PH_ADDR;
			bit_cnt         <= 3'd7;
			byte_full       <= 1'b0;
			shreg           <= 8'h00;
			rd_dir          <= 1'b0;
			ara_mode        <= 1'b0;
			drive_low       <= 1'b0;
			addr_latched    <= 1'b0;
			own_addr        <= `SSRA_ADDR_PIN_FLOAT;
			rdata_hold      <= 8'h00;
			reg_addr        <= 8'h00;
			reg_wdata       <= 8'h00;
			reg_we          <= 1'b0;
			config_one      <= `SSRA_CONFIG_ONE_RESET;
			timeout_disable <= 1'b0;
		end
		else if (ce)
		begin
			reg_we <= 1'b0;
			if (timeout_hit)
			begin
				// Abandon transfer and free SDA
				state     <= ST_IDLE;
				drive_low <= 1'b0;
			end
			else if (start)
			begin
				// Start or repeated start opens a new transfer
				state     <= ST_RECV;
				phase     <= PH_ADDR;
				bit_cnt   <= 3'd7;
				byte_full <= 1'b0;
				drive_low <= 1'b0;
				ara_mode  <= 1'b0;
				if (!addr_latched)
				begin
					own_addr     <= next_own_addr;
					addr_latched <= 1'b1;
				end
			end
			else if (stop)
			begin
				state     <= ST_IDLE;
				drive_low <= 1'b0;
			end
			else
			begin
				case (state)
				ST_IDLE, ST_SKIP:
					drive_low <= 1'b0;
				ST_RECV:
					if (scl_up)
					begin
						shreg   <= {shreg[6:0], sda};
						bit_cnt <= bit_cnt - 3'd1;
						// Eighth bit in; the fall after start ends no byte
						if (bit_cnt == 3'd0)
							byte_full <= 1'b1;
					end
					else if (scl_dn && byte_full)
					begin
						// Byte complete: decide on acknowledge
						byte_full <= 1'b0;
						state <= ST_ACK;
						case (phase)
						PH_ADDR:
							if (hit_own)
							begin
								drive_low <= 1'b1;
								rd_dir    <= shreg[0];
							end
							else if (hit_ara)
							begin
								drive_low <= 1'b1;
								rd_dir    <= 1'b1;
								ara_mode  <= 1'b1;
							end
							else
								state <= ST_SKIP;
						PH_CMD:
						begin
							drive_low <= 1'b1;
							reg_addr  <= shreg;
						end
						PH_DATA:
						begin
							drive_low <= 1'b1;
							reg_wdata <= shreg;
							reg_we    <= 1'b1;
							if (reg_addr == `SSRA_CONFIG_ONE_ADDR)
							begin
								config_one      <= shreg;
								timeout_disable <=
									shreg[`SSRA_TIMEOUT_DIS_BIT];
							end
						end
						PH_PEC:
							// Ack the extra byte only if it checks
							drive_low <= (crc == 8'h00);
						default:
							state <= ST_SKIP;
						endcase
					end
				ST_ACK:
					if (scl_dn)
					begin
						bit_cnt <= 3'd7;
						if (rd_dir && phase == PH_PEC)
						begin
							// Code byte already held: start on its top bit
							state     <= ST_SEND;
							drive_low <= ~rdata_hold[7];
						end
						else if (rd_dir)
						begin
							// Load first bit of outgoing byte
							state      <= ST_SEND;
							rdata_hold <= ara_mode
								? {own_addr, 1'b1}
								: reg_rdata;
							drive_low  <= ara_mode ? ~own_addr[6]
								: ~reg_rdata[7];
							phase      <= PH_DATA;
						end
						else
						begin
							state     <= ST_RECV;
							drive_low <= 1'b0;
							if (phase != PH_PEC)
								phase <= phase + 2'd1;
						end
					end
				ST_SEND:
					if (scl_up && !drive_low == 1'b1 && !sda)
					begin
						// Released a 1 but line low: lost
						state     <= ST_SKIP;
						drive_low <= 1'b0;
					end
					else if (scl_dn)
					begin
						if (bit_cnt == 3'd0)
						begin
							state     <= ST_RACK;
							drive_low <= 1'b0;
						end
						else
						begin
							bit_cnt   <= bit_cnt - 3'd1;
							drive_low <= ~rdata_hold[bit_cnt - 3'd1];
						end
					end
				ST_RACK:
					if (scl_up)
					begin
						if (sda)
							state <= ST_SKIP;
						else
						begin
							// Master wants one more: the PEC byte
							rdata_hold <= crc;
							state      <= ST_ACK;
							phase      <= PH_PEC;
						end
					end
				default:
					state <= ST_IDLE;
				endcase
			end
		end
	end

	// Pointer kept in reg_addr is only changed by a command byte,
	// so repeated reads keep returning the same register.

endmodule // ssra_slave

//--- core/ssra_defines.vh
// Purpose: Constants for the serial-bus slave register access block.
// Assumes: 250 MHz system clock.
// Notes:   Included by both design files.
`ifndef SSRA_DEFINES_VH
`define SSRA_DEFINES_VH

// ----------------------------------------------------------------------
// Register map
// ----------------------------------------------------------------------
`define SSRA_CONFIG_ONE_ADDR    8'h40
`define SSRA_CONFIG_ONE_RESET   8'h00
`define SSRA_TIMEOUT_DIS_BIT    3

// ----------------------------------------------------------------------
// Bus addresses
// ----------------------------------------------------------------------
`define SSRA_ALERT_RESP_ADDR    7'h0C
`define SSRA_ADDR_PIN_HIGH      7'h2F
`define SSRA_ADDR_PIN_LOW       7'h2C
`define SSRA_ADDR_PIN_FLOAT     7'h2E

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define SSRA_CLK_MHZ            250
`define SSRA_TIMEOUT_MS         31
`define SSRA_TIMEOUT_CYCLES     (`SSRA_TIMEOUT_MS * 1000 * `SSRA_CLK_MHZ)

// ----------------------------------------------------------------------
// Packet error code
// ----------------------------------------------------------------------
`define SSRA_CRC_POLY           8'h07

`endif

//--- core/ssra_crc8.v
// Purpose: Bit-serial CRC-8 accumulator for the packet error code.
// Assumes: One bit per shift strobe, most significant bit first.
// Notes:   Cleared at each start condition.
`timescale 1ns/1ps
`include "ssra_defines.vh"

module ssra_crc8
(
	// Clock and reset
	input  wire       clk,
	input  wire       rst,
	input  wire       ce,
	// Control
	input  wire       clear,
	input  wire       shift,
	input  wire       bit_in,
	// Result
	output reg  [7:0] crc
);

	// Feedback term of the shift register
	wire fb;
	assign fb = crc[7] ^ bit_in;

	// ------------------------------------------------------------------
	// Accumulator
	// ------------------------------------------------------------------
	// Shift one bit through x^8 + x^2 + x + 1
	always @(posedge clk or posedge rst)
	begin
		if (rst)
			crc <= 8'h00;
		else if (ce)
		begin
			if (clear)
				crc <= 8'h00;
			else if (shift)
				crc <= {crc[6:0], 1'b0} ^ (fb ? `SSRA_CRC_POLY : 8'h00);
		end
	end

endmodule // ssra_crc8

//--- verif/ssra_slave_sva.sv
// Purpose: Port checker for the serial-bus slave block.
// Assumes: Bound to ssra_slave; one clock domain.
// Notes:   Idle counter mirrors bus inactivity for the timeout.
`timescale 1ns/1ps
`include "ssra_defines.vh"
module ssra_slave_sva
#(
	parameter TIMEOUT_CYCLES = 2000
)
(
	// Clock and reset
	input wire       clk,
	input wire       rst,
	// Bus pins
	input wire       scl_in,
	input wire       sda_in,
	input wire       sda_oe,
	// Alert
	input wire       alert_cause,
	input wire       alert_n_oe,
	// Register side
	input wire [7:0] reg_addr,
	input wire       reg_we,
	input wire [7:0] config_one,
	input wire       timeout_disable,
	input wire [6:0] own_addr,
	input wire       timeout_hit
);
	logic [31:0] idle_cnt; // Cycles since last pin change
	logic        scl_q;    // Previous SCL sample
	logic        sda_q;    // Previous SDA sample
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	// Count cycles with no edge on either bus line
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			idle_cnt <= 32'h0;
			scl_q <= 1'b1;
			sda_q <= 1'b1;
		end
		else
		begin
			scl_q <= scl_in;
			sda_q <= sda_in;
			if (scl_in != scl_q || sda_in != sda_q)
				idle_cnt <= 32'h0;
			else
				idle_cnt <= idle_cnt + 32'h1;
		end
	end

	// Data line only moves while the bus clock is low
	sda_move_a: assert property (
		$changed(sda_oe) |-> !scl_in)
		else $error("data line moved with clock high");
	release_a: assert property (
		timeout_hit |-> ##[0:2] !sda_oe)
		else $error("data line held after timeout");
	hit_pulse_a: assert property (
		timeout_hit |=> !timeout_hit)
		else $error("timeout pulse too long");
	hit_idle_a: assert property (
		timeout_hit |-> idle_cnt >= TIMEOUT_CYCLES - 8)
		else $error("timeout before bus went idle");
	hit_off_a: assert property (
		timeout_disable |-> !timeout_hit)
		else $error("timeout while disabled");
	dis_bit_a: assert property (
		$stable(config_one) |->
		timeout_disable == config_one[`SSRA_TIMEOUT_DIS_BIT])
		else $error("disable bit not from config one");
	alert_set_a: assert property (
		$rose(alert_cause) |-> ##[1:6] alert_n_oe)
		else $error("alert line not pulled");
	alert_clr_a: assert property (
		!alert_cause [*8] |=> !alert_n_oe)
		else $error("alert line held without cause");
	we_addr_a: assert property (
		reg_we |-> $stable(reg_addr) && !$past(reg_we))
		else $error("write strobe with moving pointer");
	own_addr_a: assert property (
		own_addr inside {`SSRA_ADDR_PIN_HIGH,
		`SSRA_ADDR_PIN_LOW, `SSRA_ADDR_PIN_FLOAT})
		else $error("device address not a legal code");
endmodule // ssra_slave_sva

//--- verif/ssra_host.sv
// Purpose: Bus host model driving SCL and pulling SDA low.
// Assumes: SDA is wired-AND with a pull-up in the bench.
// Notes:   Quarter bit time 8 ns (32 ns bus clock); SCL idles high.
`timescale 1ns/1ps
module ssra_host
(
	// Bus lines
	input  wire  sda,
	output logic scl,
	output logic sda_low
);
	localparam int Q = 8; // Quarter bit time in ns

	initial
	begin
		scl = 1'b1;
		sda_low = 1'b0;
	end

	// Start or repeated start: SDA falls while SCL is high
	task start();
		#Q sda_low = 1'b0;
		#Q scl = 1'b1;
		#Q sda_low = 1'b1;
		#Q scl = 1'b0;
	endtask

	// Stop: SDA rises while SCL is high
	task stop();
		#Q sda_low = 1'b1;
		#Q scl = 1'b1;
		#Q sda_low = 1'b0;
		#Q;
	endtask

	// One bit: drive during low, sample in mid high
	task bit_io(input logic b, output logic r);
		#Q sda_low = !b;
		#Q scl = 1'b1;
		#Q r = sda;
		#Q scl = 1'b0;
	endtask

	// Byte MSB first, then the ninth bit; ma high releases it
	task byte_io(input logic [7:0] d, input logic ma,
		output logic [7:0] q, output logic k);
		for (int i = 7; i >= 0; i--)
			bit_io(d[i], q[i]);
		bit_io(ma, k);
	endtask
endmodule // ssra_host

//--- verif/ssra_slave_tb.sv
// Purpose: Self-checking bench for the serial-bus slave block.
// Assumes: Host model owns SCL; registers live in a bench array.
// Notes:   Timeout shortened to 2000 cycles.
`timescale 1ns/1ps
`include "ssra_defines.vh"
module ssra_slave_tb;
	localparam logic [6:0] ADR = `SSRA_ADDR_PIN_FLOAT;
	logic       clk, rst, scl, sda_low, alert_cause, addr_sel_high;
	wire        sda_oe, sda_out, reg_we, timeout_hit, sda;
	wire        timeout_disable, alert_n_oe;
	wire  [7:0] reg_addr, reg_wdata, config_one;
	wire  [6:0] own_addr;
	logic [7:0] mem [256]; // External register file
	logic [7:0] q;         // Last byte read
	logic       k;         // Last ninth-bit level
	int         err_total, n_tests, cyc, hit_cnt;

	assign sda = !(sda_low || (sda_oe && !sda_out));

	ssra_slave #(.TIMEOUT_CYCLES(2000)) i_ssra_slave
	(
		.clk(clk), .rst(rst), .ce(1'b1), .scl_in(scl), .sda_in(sda),
		.sda_out(sda_out), .sda_oe(sda_oe), .addr_sel_high(addr_sel_high),
		.addr_sel_low(1'b0), .alert_cause(alert_cause), .alert_n_out(),
		.alert_n_oe(alert_n_oe), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_we(reg_we), .reg_rdata(mem[reg_addr]),
		.config_one(config_one), .timeout_disable(timeout_disable),
		.own_addr(own_addr), .timeout_hit(timeout_hit)
	);
	ssra_host i_ssra_host (.sda(sda), .scl(scl), .sda_low(sda_low));

	initial
	begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end

	// Register writes, timeout pulses and the watchdog
	always @(posedge clk)
	begin
		if (reg_we)
			mem[reg_addr] <= reg_wdata;
		if (timeout_hit)
			hit_cnt++;
		cyc++;
		if (cyc == 40000)
		begin
			err_total++;
			end_sim();
		end
	end

	task chk(input logic [7:0] got, input logic [7:0] exp);
		n_tests++;
		if (got !== exp)
		begin
			err_total++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task end_sim();
		$display("comparisons=%0d mismatches=%0d", n_tests, err_total);
		if (err_total == 0 && n_tests > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	function automatic logic [7:0] crc(input logic [15:0] v);
		logic [7:0] c = 8'h00;
		for (int i = 15; i >= 0; i--)
			c = {c[6:0], 1'b0} ^ ((c[7] ^ v[i]) ? 8'h07 : 8'h00);
		return c;
	endfunction

	// Start aligned just after a clock edge
	task start();
		@(posedge clk);
		#1 i_ssra_host.start();
	endtask

	// Host sends a byte that the device must acknowledge
	task put(input logic [7:0] d);
		i_ssra_host.byte_io(d, 1'b1, q, k);
		chk({7'h00, k}, 8'h00);
	endtask

	task wr(input logic [7:0] a, input logic [7:0] d);
		start();
		put({ADR, 1'b0});
		put(a);
		put(d);
		i_ssra_host.stop();
	endtask

	// Receive byte after a start; optional packet error code
	task rd(input logic [7:0] e, input logic pec);
		put({ADR, 1'b1});
		i_ssra_host.byte_io(8'hFF, !pec, q, k);
		chk(q, e);
		if (pec)
		begin
			i_ssra_host.byte_io(8'hFF, 1'b1, q, k);
			chk(q, crc({ADR, 1'b1, e}));
		end
		i_ssra_host.stop();
	endtask

	task t_write();
		wr(8'h12, 8'hA5);
		chk(mem[8'h12], 8'hA5);
		chk({1'b0, own_addr}, {1'b0, ADR});
		repeat (2)
		begin
			start();
			rd(8'hA5, 1'b0);
		end
	endtask

	task t_send_rs();
		start();
		put({ADR, 1'b0});
		put(8'h13);
		start();
		rd(8'h13 ^ 8'h5A, 1'b0);
		start();
		rd(8'h13 ^ 8'h5A, 1'b1);
	endtask

	// Pin moves after the first transfer; address must not follow
	task t_addr();
		@(posedge clk);
		#1 addr_sel_high = 1'b1;
		start();
		i_ssra_host.byte_io({`SSRA_ADDR_PIN_HIGH, 1'b0}, 1'b1, q, k);
		chk({7'h00, k}, 8'h01);
		i_ssra_host.stop();
		chk({1'b0, own_addr}, {1'b0, ADR});
	endtask

	task t_alert();
		@(posedge clk);
		#1 alert_cause = 1'b1;
		repeat (10) @(posedge clk);
		chk({7'h00, alert_n_oe}, 8'h01);
		start();
		put({`SSRA_ALERT_RESP_ADDR, 1'b1});
		i_ssra_host.byte_io(8'hFF, 1'b1, q, k);
		chk(q, {ADR, 1'b1});
		i_ssra_host.stop();
		chk({7'h00, alert_n_oe}, 8'h01);
		// A rival at 0x2B sends 0x57: it wins at bit 3, we must withdraw
		start();
		put({`SSRA_ALERT_RESP_ADDR, 1'b1});
		i_ssra_host.byte_io(8'h57, 1'b1, q, k);
		chk(q, 8'h57);
		i_ssra_host.stop();
		@(posedge clk);
		#1 alert_cause = 1'b0;
		repeat (10) @(posedge clk);
		chk({7'h00, alert_n_oe}, 8'h00);
	endtask

	// Hold SCL low mid-transfer and count timeout pulses; a read
	// leaves the device pulling SDA for the top bit of a 0x00 register
	task stall(input logic r, input logic [7:0] n);
		int h;
		h = hit_cnt;
		start();
		put({ADR, r});
		repeat (100) @(posedge clk);
		chk({7'h00, sda_oe}, {7'h00, r});
		repeat (2500) @(posedge clk);
		chk(8'(hit_cnt - h), n);
		chk({7'h00, sda_oe}, 8'h00);
		i_ssra_host.stop();
	endtask

	task t_timeout();
		chk(config_one, `SSRA_CONFIG_ONE_RESET);
		wr(`SSRA_CONFIG_ONE_ADDR, 8'h08);
		chk(config_one, 8'h08);
		chk({7'h00, timeout_disable}, 8'h01);
		stall(1'b0, 8'h00);
		wr(`SSRA_CONFIG_ONE_ADDR, 8'h00);
		stall(1'b1, 8'h01);
	endtask

	initial
	begin
		rst = 1'b1;
		alert_cause = 1'b0;
		addr_sel_high = 1'b0;
		err_total = 0;
		n_tests = 0;
		cyc = 0;
		hit_cnt = 0;
		for (int i = 0; i < 256; i++)
			mem[i] = 8'(i) ^ 8'h5A;
		repeat (16) @(posedge clk);
		#1 rst = 1'b0;
		repeat (8) @(posedge clk);
		t_write();
		t_send_rs();
		t_addr();
		t_alert();
		t_timeout();
		end_sim();
	end
endmodule // ssra_slave_tb

bind ssra_slave ssra_slave_sva #(.TIMEOUT_CYCLES(TIMEOUT_CYCLES))
	i_ssra_slave_sva
(
	.clk(clk), .rst(rst), .scl_in(scl_in), .sda_in(sda_in),
	.sda_oe(sda_oe), .alert_cause(alert_cause), .alert_n_oe(alert_n_oe),
	.reg_addr(reg_addr), .reg_we(reg_we), .config_one(config_one),
	.timeout_disable(timeout_disable), .own_addr(own_addr),
	.timeout_hit(timeout_hit)
);
